// File: rtl/rgc_gain_ctrl.sv
// receiver gain loop, digital gain tracker and register slave
`timescale 1ns/1ps

// Behaviour
// - gain select 000 automatic, 001..110 fixed max..-48 dB, 111 reserved
// - gain select resets to automatic
// - on receive enable wait for two consecutive samples above threshold
// - then pick one of six gain steps without software
// - chosen step frozen for the packet and readable as applied gain
// - packet mode, auto restart off: keep step for next packet
// - auto restart on: after FIFO empties and wait, return to waiting
// - writing one to restart receive forces waiting and new selection
// - continuous mode keeps step until software restarts receive
// - with automatic AFC, AFC bandwidth used during AFC and selection
// - reference is -174 + 7 + 8 + 10log(2*bandwidth) + 5 dBm
// - five ascending thresholds map input power onto six steps
// - digital gain readjusted every two bit periods, even if frozen
// - tracker works in continuous and both packet operations
// - one-bit I and Q streams decimated and filtered
// - strength value in 0.5 dB units, acquired over two bit periods
// - strength value readable only above the threshold
module rgc_gain_ctrl
  import rgc_pkg::*;
#(
  parameter int DEC_LOG2  = 4,
  parameter int TH_OFF1   = 10,
  parameter int TH_OFF2   = 16,
  parameter int TH_OFF3   = 24,
  parameter int TH_OFF4   = 36,
  parameter int TH_OFF5   = 48,
  parameter int DG_TGT_HI = 200,
  parameter int DG_TGT_LO = 180
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxEnable,
  input  wire logic        bitTick,
  input  wire logic        packetDone,
  input  wire logic        fifoEmpty,
  input  wire logic        sdIPin,
  input  wire logic        sdQPin,
  output logic [2:0]       lnaGainQ,
  output logic             afcBwSelQ,
  output logic [3:0]       digGainQ,
  output logic             waitingQ
);

  localparam int SW = DEC_LOG2 + 2;

  rgc_state_t stateQ, stateD;
  logic [2:0]  gainSelQ;
  logic        autoRstQ, pktModeQ, afcAutoQ, restartQ;
  logic [7:0]  threshQ, ipWaitQ, chBwQ, afcBwQ, dgCtrlQ;
  logic [2:0]  autoGainQ;
  logic [7:0]  strengthQ;
  logic        strengthVldQ;
  logic [15:0] accQ;
  logic        acqPhaseQ;
  logic [1:0]  hitCntQ;
  logic [7:0]  delayCntQ;
  logic [1:0]  syncIQ, syncQQ;
  logic signed [SW-1:0] decI, decQ;
  logic        decIVld, decQVld;
  logic [SW-1:0] magI, magQ;
  logic        awHaveQ, wHaveQ, doWrite;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        above, restartSet;
  logic signed [11:0] refDbm;
  logic [2:0]  pickStep;
  logic [31:0] rdMux;
  logic        rdErr;

  // pins cross into mclk through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncIQ <= 2'h0;
      syncQQ <= 2'h0;
    end
    else if (clkEn)
    begin
      syncIQ <= {syncIQ[0], sdIPin};
      syncQQ <= {syncQQ[0], sdQPin};
    end
  end

  rgc_decimator #(.DEC_LOG2(DEC_LOG2)) decIInst (
    .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
    .bitIn(syncIQ[1]), .sampleQ(decI), .validQ(decIVld));
  rgc_decimator #(.DEC_LOG2(DEC_LOG2)) decQInst (
    .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
    .bitIn(syncQQ[1]), .sampleQ(decQ), .validQ(decQVld));

  assign magI = decI[SW-1] ? SW'(-decI) : SW'(decI);
  assign magQ = decQ[SW-1] ? SW'(-decQ) : SW'(decQ);

  // two bit periods of amplitude, saturated to 0.5 dB units
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accQ         <= '0;
      acqPhaseQ    <= 1'b0;
      strengthQ    <= '0;
      strengthVldQ <= 1'b0;
    end
    else if (clkEn)
    begin
      strengthVldQ <= 1'b0;
      if (bitTick)
      begin
        acqPhaseQ <= ~acqPhaseQ;
        if (acqPhaseQ)
        begin
          accQ         <= '0;
          strengthQ    <= (|accQ[15:8]) ? 8'hff : accQ[7:0];
          strengthVldQ <= 1'b1;
        end
      end
      else if (decIVld && decQVld && !(&accQ))
      begin
        accQ <= accQ + 16'(magI) + 16'(magQ);
      end
    end
  end

  assign above = strengthQ > threshQ;

  // reference level from the bandwidth term in use
  assign refDbm = 12'(THERMAL_DBM + NOISE_FIG_DB + DEMOD_SNR_DB
                      + FADE_MARG_DB)
                  + 12'(afcBwSelQ ? afcBwQ : chBwQ);

  // count thresholds passed, one step per band
  always_comb
  begin
    int th [NUM_THRESH];
    int pinHd;
    pickStep = GAIN_MAX;
    th[0] = TH_OFF1;
    th[1] = TH_OFF2;
    th[2] = TH_OFF3;
    th[3] = TH_OFF4;
    th[4] = TH_OFF5;
    pinHd = int'(strengthQ);
    for (int k = 0; k < NUM_THRESH; k++)
    begin
      if (pinHd > 2 * (int'(refDbm) + th[k] - FLOOR_DBM))
        pickStep = pickStep + 3'h1;
    end
  end

  // gain loop sequence
  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      RGC_IDLE:
        if (rxEnable)
          stateD = RGC_WAIT;
      RGC_WAIT:
        if (strengthVldQ && above && hitCntQ == 2'(CONSEC_HITS - 1))
          stateD = RGC_SELECT;
      RGC_SELECT:
        stateD = RGC_HOLD;
      // step kept unless auto restart applies
      RGC_HOLD:
        if (pktModeQ && autoRstQ && packetDone)
          stateD = RGC_DRAIN;
      // wait for the FIFO to empty, then the inter-packet wait
      RGC_DRAIN:
        if (fifoEmpty)
          stateD = RGC_DELAY;
      RGC_DELAY:
        if (delayCntQ == 8'h00)
          stateD = RGC_WAIT;
      default:
        stateD = RGC_IDLE;
    endcase
    if (restartQ && stateQ != RGC_IDLE)
      stateD = RGC_WAIT;
    if (!rxEnable)
      stateD = RGC_IDLE;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateQ    <= RGC_IDLE;
      hitCntQ   <= 2'h0;
      delayCntQ <= 8'h00;
      autoGainQ <= GAIN_MAX;
    end
    else if (clkEn)
    begin
      stateQ <= stateD;
      if (stateQ != RGC_WAIT || stateD != RGC_WAIT)
        hitCntQ <= 2'h0;
      else if (strengthVldQ)
        hitCntQ <= above ? hitCntQ + 2'h1 : 2'h0;
      if (stateQ == RGC_DRAIN)
        delayCntQ <= ipWaitQ;
      else if (stateQ == RGC_DELAY && bitTick && delayCntQ != 8'h00)
        delayCntQ <= delayCntQ - 8'h01;
      if (stateQ == RGC_SELECT)
        autoGainQ <= pickStep;
    end
  end

  // drive the front-end gain, AFC bandwidth and wait status
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lnaGainQ  <= GAIN_MAX;
      afcBwSelQ <= 1'b0;
      waitingQ  <= 1'b0;
    end
    else if (clkEn)
    begin
      // fixed codes pass, automatic and reserved use the loop
      if (gainSelQ == GAIN_AUTO || gainSelQ == GAIN_RSVD)
        lnaGainQ <= (stateQ == RGC_SELECT) ? pickStep
                    : (stateD == RGC_HOLD) ? autoGainQ : lnaGainQ;
      else
        lnaGainQ <= gainSelQ;
      // AFC bandwidth during waiting and selection
      afcBwSelQ <= afcAutoQ
                   && (stateD == RGC_WAIT || stateD == RGC_SELECT);
      waitingQ  <= stateD == RGC_WAIT;
    end
  end

  // tracker steps on each two-bit strength update
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      digGainQ <= 4'h0;
    else if (clkEn)
    begin
      if (!dgCtrlQ[DG_EN_BIT])
        digGainQ <= 4'h0;
      else if (strengthVldQ)
      begin
        // low index mode aims lower to leave headroom for offset
        if (int'(strengthQ) + DGAIN_STEP_HD * int'(digGainQ)
            > (dgCtrlQ[DG_NORMAL_BIT] ? DG_TGT_HI : DG_TGT_LO)
            && digGainQ != 4'h0)
          digGainQ <= digGainQ - 4'h1;
        else if (int'(strengthQ) + DGAIN_STEP_HD * int'(digGainQ)
                 < DG_TGT_LO - DGAIN_STEP_HD && digGainQ != 4'hf)
          digGainQ <= digGainQ + 4'h1;
      end
    end
  end

  // write address and data taken in either order
  assign doWrite = awHaveQ && wHaveQ && !s_axi_bvalid;
  assign restartSet = doWrite && awAddrQ == CFG_OFF && wStrbQ[0]
                      && wDataQ[RESTART_BIT];

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHaveQ       <= 1'b0;
      wHaveQ        <= 1'b0;
      awAddrQ       <= 8'h00;
      wDataQ        <= 32'h0;
      wStrbQ        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHaveQ       <= 1'b1;
        awAddrQ       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (!awHaveQ && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHaveQ       <= 1'b1;
        wDataQ       <= s_axi_wdata;
        wStrbQ       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!wHaveQ && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (doWrite)
      begin
        awHaveQ      <= 1'b0;
        wHaveQ       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddrQ > DGCTRL_OFF || awAddrQ[1:0] != 2'h0)
                        ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gainSelQ <= GAINSEL_RST;
      autoRstQ <= 1'b0;
      pktModeQ <= 1'b0;
      afcAutoQ <= 1'b0;
      threshQ  <= THRESH_RST;
      ipWaitQ  <= IPWAIT_RST;
      chBwQ    <= CHBW_RST;
      afcBwQ   <= AFCBW_RST;
      dgCtrlQ  <= DGCTRL_RST;
    end
    else if (clkEn && doWrite)
    begin
      if (awAddrQ == CFG_OFF && wStrbQ[0])
      begin
        gainSelQ <= wDataQ[GAINSEL_LSB +: 3];
        autoRstQ <= wDataQ[AUTORST_BIT];
        pktModeQ <= wDataQ[PKTMODE_BIT];
        afcAutoQ <= wDataQ[AFCAUTO_BIT];
      end
      if (awAddrQ == THRESH_OFF && wStrbQ[0])
        threshQ <= wDataQ[7:0];
      if (awAddrQ == IPWAIT_OFF && wStrbQ[0])
        ipWaitQ <= wDataQ[7:0];
      if (awAddrQ == BW_OFF && wStrbQ[0])
        chBwQ <= wDataQ[7:0];
      if (awAddrQ == BW_OFF && wStrbQ[1])
        afcBwQ <= wDataQ[AFCBW_LSB +: 8];
      if (awAddrQ == DGCTRL_OFF && wStrbQ[0])
        dgCtrlQ <= wDataQ[7:0];
    end
  end

  // self-clearing restart, a new write wins over the clear
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      restartQ <= 1'b0;
    else if (clkEn)
    begin
      if (restartSet)
        restartQ <= 1'b1;
      else if (stateQ == RGC_WAIT)
        restartQ <= 1'b0;
    end
  end

  // read data mux
  always_comb
  begin
    rdMux = 32'h0;
    rdErr = 1'b0;
    case (s_axi_araddr)
      CFG_OFF:
        rdMux = {24'h0, restartQ, 1'b0, afcAutoQ, pktModeQ, autoRstQ,
                 gainSelQ};
      THRESH_OFF:   rdMux = {24'h0, threshQ};
      IPWAIT_OFF:   rdMux = {24'h0, ipWaitQ};
      BW_OFF:       rdMux = {16'h0, afcBwQ, chBwQ};
      DGCTRL_OFF:   rdMux = {24'h0, dgCtrlQ};
      STATUS_OFF:
        rdMux = {20'h0, digGainQ, 1'b0, stateQ, 1'b0, lnaGainQ};
      STRENGTH_OFF: rdMux = {24'h0, above ? strengthQ : 8'h00};
      default:      rdErr = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else if (clkEn)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= rdErr ? 2'h2 : 2'h0;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule // rgc_gain_ctrl

// File: shared/rgc_pkg.sv
// constants and types shared by the receiver gain control block
package rgc_pkg;

  // register byte offsets
  localparam logic [7:0] CFG_OFF       = 8'h00;
  localparam logic [7:0] THRESH_OFF    = 8'h04;
  localparam logic [7:0] IPWAIT_OFF    = 8'h08;
  localparam logic [7:0] BW_OFF        = 8'h0c;
  localparam logic [7:0] DGCTRL_OFF    = 8'h10;
  localparam logic [7:0] STATUS_OFF    = 8'h14;
  localparam logic [7:0] STRENGTH_OFF  = 8'h18;

  // configuration and status register field positions
  localparam int GAINSEL_LSB   = 0;
  localparam int AUTORST_BIT   = 3;
  localparam int PKTMODE_BIT   = 4;
  localparam int AFCAUTO_BIT   = 5;
  localparam int RESTART_BIT   = 7;
  localparam int AFCBW_LSB     = 8;
  localparam int DG_EN_BIT     = 5;
  localparam int DG_NORMAL_BIT = 4;
  localparam int ST_STATE_LSB  = 4;
  localparam int ST_DGAIN_LSB  = 8;

  // reset values
  localparam logic [2:0] GAINSEL_RST  = 3'h0;
  localparam logic [7:0] THRESH_RST   = 8'hff;
  localparam logic [7:0] IPWAIT_RST   = 8'h00;
  localparam logic [7:0] CHBW_RST     = 8'h34;
  localparam logic [7:0] AFCBW_RST    = 8'h36;
  localparam logic [7:0] DGCTRL_RST   = 8'h30;

  // gain select codes
  localparam logic [2:0] GAIN_AUTO    = 3'h0;
  localparam logic [2:0] GAIN_MAX     = 3'h1;
  localparam logic [2:0] GAIN_MIN     = 3'h6;
  localparam logic [2:0] GAIN_RSVD    = 3'h7;

  // timing counts, in bit periods and samples
  localparam int ACQ_BITS      = 2;
  localparam int CONSEC_HITS   = 2;

  // reference level terms in dB, strength scale in 0.5 dB units
  localparam int THERMAL_DBM   = -174;
  localparam int NOISE_FIG_DB  = 7;
  localparam int DEMOD_SNR_DB  = 8;
  localparam int FADE_MARG_DB  = 5;
  localparam int FLOOR_DBM     = -128;
  localparam int NUM_THRESH    = 5;
  localparam int DGAIN_STEP_HD = 12;

  typedef enum logic [2:0] {
    RGC_IDLE, RGC_WAIT, RGC_SELECT, RGC_HOLD, RGC_DRAIN, RGC_DELAY
  } rgc_state_t;

endpackage

// File: rtl/rgc_decimator.sv
// one-bit sigma-delta stream decimator, ones count over a block
`timescale 1ns/1ps
module rgc_decimator
  import rgc_pkg::*;
#(
  parameter int DEC_LOG2 = 4
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  input  wire logic                bitIn,
  output logic signed [DEC_LOG2+1:0] sampleQ,
  output logic                     validQ
);

  logic [DEC_LOG2-1:0] phaseQ;
  logic [DEC_LOG2:0]   onesQ;
  logic [DEC_LOG2:0]   onesD;

  assign onesD = onesQ + {{DEC_LOG2{1'b0}}, bitIn};

  // block sum mapped to a signed value centred on zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseQ  <= '0;
      onesQ   <= '0;
      sampleQ <= '0;
      validQ  <= 1'b0;
    end
    else if (clkEn)
    begin
      phaseQ <= phaseQ + 1'b1;
      validQ <= &phaseQ;
      if (&phaseQ)
      begin
        onesQ   <= '0;
        // half a full block is zero, so both rails read as strong
        sampleQ <= $signed({1'b0, onesD})
                   - $signed({3'b001, {(DEC_LOG2-1){1'b0}}});
      end
      else
      begin
        onesQ <= onesD;
      end
    end
  end

endmodule // rgc_decimator

// File: testbench/rgc_gain_ctrl_props.sv
// port checker for the receiver gain control block
`timescale 1ns/1ps
module rgc_gain_ctrl_props
  import rgc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rxEnable,
  input wire logic [2:0]  lnaGainQ,
  input wire logic        waitingQ
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // register writes excused: a fixed code may legally move the gain
  sequence steadyHold;
    (rxEnable && !waitingQ && !s_axi_bvalid)[*4];
  endsequence

  AST_B_AFTER_WRITE: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_REFUSE: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_R_AFTER_ADDR: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_GAIN_CODE: assert property (lnaGainQ inside {[3'h1:3'h6]})
    else $error("gain step out of range");
  AST_ENABLE_WAIT: assert property ($rose(rxEnable) |-> ##[2:3] waitingQ)
    else $error("waiting not entered on enable");
  AST_IDLE: assert property (!rxEnable [*2] |=> !waitingQ)
    else $error("waiting while receiver disabled");
  AST_FROZEN: assert property (steadyHold |-> $stable(lnaGainQ))
    else $error("gain moved while held");
endmodule // rgc_gain_ctrl_props

// File: testbench/rgc_gain_ctrl_tb.sv
// self-checking bench for the receiver gain control block
`timescale 1ns/1ps
module rgc_gain_ctrl_tb;
  import rgc_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clkEn = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        rxEnable = 1'b0;
  logic        bitTick = 1'b0;
  logic        packetDone = 1'b0;
  logic        fifoEmpty = 1'b1;
  logic        sdIPin = 1'b0;
  logic        sdQPin = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, afcBwSelQ, waitingQ;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rv;
  logic [2:0]  lnaGainQ, g;
  logic [3:0]  digGainQ;
  logic [2:0]  tickCnt = 3'h0;
  int          badCount = 0;
  int          checked = 0;

  always #2.5 mclk = ~mclk;
  // one bit period every eight clocks keeps strength updates quick
  always @(posedge mclk)
  begin
    tickCnt <= tickCnt + 3'h1;
    bitTick <= (tickCnt == 3'h7);
  end

  rgc_gain_ctrl #(.DEC_LOG2(2)) dut (
    .mclk, .reset_n, .clkEn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxEnable, .bitTick,
    .packetDone, .fifoEmpty, .sdIPin, .sdQPin, .lnaGainQ, .afcBwSelQ,
    .digGainQ, .waitingQ
  );

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      badCount++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // a used-up bound ends the run at once
  task automatic bound(input int k);
    if (k >= 2000)
    begin
      badCount++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 2000);
    bound(k);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    int k;
    k = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 2000);
    bound(k);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge mclk);
  endtask

  task automatic wt(input logic v);
    int k;
    k = 0;
    while (waitingQ !== v && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    bound(k);
    chk({31'h0, waitingQ}, {31'h0, v});
  endtask

  task automatic endPacket;
    packetDone <= 1'b1;
    cyc(1);
    packetDone <= 1'b0;
  endtask

  initial
  begin
    cyc(16);
    reset_n <= 1'b1;
    cyc(2);
    rd(CFG_OFF, 2'h0, rv);
    chk(rv, 32'h0);
    rd(THRESH_OFF, 2'h0, rv);
    chk(rv, {24'h0, THRESH_RST});
    rd(BW_OFF, 2'h0, rv);
    chk(rv, {16'h0, AFCBW_RST, CHBW_RST});
    rd(8'h1c, 2'h2, rv);
    wr(STATUS_OFF, 32'h7, 2'h2);
    wr(DGCTRL_OFF, 32'h20, 2'h0);
    rd(DGCTRL_OFF, 2'h0, rv);
    chk(rv, 32'h20);
    wr(DGCTRL_OFF, {24'h0, DGCTRL_RST}, 2'h0);
    // full-scale streams: strongest possible input
    sdIPin <= 1'b1;
    sdQPin <= 1'b1;
    rxEnable <= 1'b1;
    wt(1'b1);
    cyc(200);
    wt(1'b1);
    rd(STRENGTH_OFF, 2'h0, rv);
    chk(rv, 32'h0);
    wr(THRESH_OFF, 32'h0, 2'h0);
    wt(1'b0);
    cyc(2);
    g = lnaGainQ;
    chk({29'h0, g}, {29'h0, GAIN_MAX});
    rd(STATUS_OFF, 2'h0, rv);
    chk({29'h0, rv[2:0]}, {29'h0, g});
    rd(STRENGTH_OFF, 2'h0, rv);
    chk(rv, 32'h8);
    cyc(200);
    chk({29'h0, lnaGainQ}, {29'h0, g});
    // strength 8 plus 12 per step settles the tracker at 14
    chk({28'h0, digGainQ}, 32'he);
    wr(DGCTRL_OFF, 32'h0, 2'h0);
    chk({28'h0, digGainQ}, 32'h0);
    wr(DGCTRL_OFF, {24'h0, DGCTRL_RST}, 2'h0);
    wr(CFG_OFF, 32'h80, 2'h0);
    wt(1'b1);
    rd(CFG_OFF, 2'h0, rv);
    chk(rv, 32'h0);
    wt(1'b0);
    wr(CFG_OFF, 32'h10, 2'h0);
    endPacket();
    cyc(300);
    wt(1'b0);
    chk({28'h0, digGainQ}, 32'he);
    wr(IPWAIT_OFF, 32'h4, 2'h0);
    wr(CFG_OFF, 32'h18, 2'h0);
    fifoEmpty <= 1'b0;
    endPacket();
    cyc(100);
    wt(1'b0);
    fifoEmpty <= 1'b1;
    cyc(10);
    wt(1'b0);
    wt(1'b1);
    wt(1'b0);
    rxEnable <= 1'b0;
    cyc(4);
    wt(1'b0);
    wr(CFG_OFF, 32'h20, 2'h0);
    rxEnable <= 1'b1;
    wt(1'b1);
    chk({31'h0, afcBwSelQ}, 32'h1);
    wt(1'b0);
    // channel term kept, AFC term zero: three bands passed only via AFC
    wr(BW_OFF, 32'h34, 2'h0);
    wr(CFG_OFF, 32'ha0, 2'h0);
    wt(1'b1);
    wt(1'b0);
    cyc(2);
    chk({29'h0, lnaGainQ}, 32'h4);
    for (int c = 1; c <= 6; c++)
    begin
      wr(CFG_OFF, 32'(c), 2'h0);
      cyc(8);
      chk({29'h0, lnaGainQ}, 32'(c));
      rd(STATUS_OFF, 2'h0, rv);
      chk({29'h0, rv[2:0]}, 32'(c));
    end
    // reserved code falls back to the loop's held step
    wr(CFG_OFF, 32'h7, 2'h0);
    cyc(2);
    chk({29'h0, lnaGainQ}, 32'h4);
    rxEnable <= 1'b0;
    cyc(4);
    conclude();
  end
endmodule // rgc_gain_ctrl_tb

bind rgc_gain_ctrl rgc_gain_ctrl_props u_props (
  .mclk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .rxEnable, .lnaGainQ, .waitingQ
);
